// *** pkg/nibble_alu_pkg.sv ***
// constants, opcodes and field layout for the nibble alu datapath
// assumes an instruction decoder that issues one operation at a time and a
// synchronous data memory that returns read data one cycle after the read
// Behaviour
// - with decimal mode set, every sum or difference goes through the decimal adjuster.
// - arithmetic, logic, bit test, compare, rotate and move work on memory nibbles.
// - two hidden 4-bit operand latches are filled by the sequencer, never by software.
// - no general register operation takes an immediate; immediates pair with memory only.
// - binary mode without compare-only writes the binary result to the destination.
// - sums and differences not stored to the status word set carry on carry or borrow out, otherwise clear it.
// - without compare-only and with a destination other than the status word, zero is set for a zero result and cleared otherwise.
// - with compare-only, sums and differences update flags but never the destination.
// - with compare-only, zero holds on a zero result and clears on a nonzero one.
// - decimal mode without compare-only writes the adjusted result to the destination.
// - indirect moves take a general register's content to form the indirect address.
// - adjustment is exact only for sums 0..19 and differences -10..9, else carry and >= ten.
// - arithmetic aimed at the status word without compare-only stores the result there.
package nibble_alu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // data memory layout (bank bit, row, column)
   localparam logic [3:0] GR_ROW_BANK  = 4'h0;
   localparam logic [6:0] SYS_PSW_ADDR = 7'h7F;
   localparam logic [6:0] SYS_BCD_ADDR = 7'h7E;
   // status nibble at the system address
   localparam int unsigned PSW_Z_POS   = 1;
   localparam int unsigned PSW_CARRY_POS = 2;
   localparam int unsigned PSW_CONLY_POS = 3;

   ////////////////////////////////////////////////////////////////////////////
   // apb map
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_STATE  = 12'h004;
   localparam logic [11:0] OFS_RESULT = 12'h008;
   // status register fields
   localparam int unsigned ST_ZERO_POS  = 0;
   localparam int unsigned ST_CARRY_POS = 1;
   localparam int unsigned ST_CONLY_POS = 2;
   localparam int unsigned ST_BCD_POS   = 3;
   localparam logic [3:0]  STATUS_RST   = 4'h0;
   // state register fields
   localparam int unsigned SR_BUSY_POS = 0;
   localparam int unsigned SR_SKIP_POS = 1;

   ////////////////////////////////////////////////////////////////////////////
   // decimal adjuster thresholds
   localparam logic [4:0] DEC_TEN       = 5'h0A;
   localparam logic [4:0] DEC_TWENTY    = 5'h14;
   localparam logic [4:0] DEC_TWENTY8   = 5'h1C;
   localparam logic [3:0] DEC_SIX       = 4'h6;
   localparam logic [3:0] DEC_TWO       = 4'h2;

   typedef enum logic [4:0] {
      OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_BORROW,
      OP_AND, OP_OR, OP_XOR,
      OP_BITS_TRUE, OP_BITS_FALSE,
      OP_EQUAL, OP_UNEQUAL, OP_GREATER_EQUAL, OP_LESS,
      OP_LOAD, OP_STORE, OP_MOVE_TO_IND, OP_MOVE_FROM_IND,
      OP_ROTATE
   } op_t;

endpackage

// *** logic/decimal_adjuster.sv ***
// decimal adjuster: maps a raw 5-bit sum or difference to the bcd nibble
// assumes raw holds {carry_or_borrow, nibble} of a 4-bit operation
`timescale 1ns/1ps
module decimal_adjuster (
   // raw result
   input  wire logic [4:0] raw,
   input  wire logic       is_sub,
   // adjusted result
   output logic       [3:0] adj,
   output logic             adj_carry
);

   // out of range results other than sums of 28 and up land in 1100..1111 in the same cycle of four
   function automatic logic [3:0] wrap_high(input logic [1:0] low);
      logic [1:0] t;
      t = low + nibble_alu_pkg::DEC_TWO[1:0];
      return {2'b11, t};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // exact only in range
   always_comb begin
      adj       = raw[3:0];
      adj_carry = 1'b1;
      if (!is_sub) begin
         if (raw < nibble_alu_pkg::DEC_TEN) begin
            adj_carry = 1'b0;
         end else if (raw < nibble_alu_pkg::DEC_TWENTY) begin
            adj = raw[3:0] + nibble_alu_pkg::DEC_SIX;
         end else if (raw < nibble_alu_pkg::DEC_TWENTY8) begin
            adj = wrap_high(raw[1:0]);
         end else begin
            adj = raw[3:0] - nibble_alu_pkg::DEC_TWO;
         end
      end else if (!raw[4]) begin
         if (raw < nibble_alu_pkg::DEC_TEN) begin
            adj_carry = 1'b0;
         end else begin
            adj = wrap_high(raw[1:0]);
         end
      end else if (raw[3:0] >= nibble_alu_pkg::DEC_SIX) begin
         adj = raw[3:0] - nibble_alu_pkg::DEC_SIX;
      end else begin
         adj = wrap_high(raw[1:0]);
      end
   end

endmodule // decimal_adjuster

// *** logic/nibble_addr_ctrl.sv ***
// data memory address control: forms register, direct and indirect addresses
// assumes addresses are {bank, row[2:0], column[3:0]}
`timescale 1ns/1ps
module nibble_addr_ctrl (
   // operation fields
   input  wire logic [3:0] op_reg,
   input  wire logic [7:0] op_mem,
   input  wire logic       reg_dest,
   input  wire logic       to_ind,
   input  wire logic       from_ind,
   input  wire logic       reg_only,
   // register content for the indirect column
   input  wire logic [3:0] ind_col,
   // addresses
   output logic       [7:0] first_addr,
   output logic       [7:0] second_addr,
   output logic       [7:0] dest_addr
);

   wire logic [7:0] gr_addr;
   wire logic [7:0] ind_addr;
   wire logic       gr_first;

   assign gr_addr  = {nibble_alu_pkg::GR_ROW_BANK, op_reg};
   assign ind_addr = {op_mem[7:4], ind_col};
   assign gr_first = reg_dest | to_ind | from_ind | reg_only;

   assign first_addr  = gr_first ? gr_addr : op_mem;
   assign second_addr = from_ind ? ind_addr : (gr_first ? op_mem : gr_addr);
   assign dest_addr   = to_ind ? ind_addr : (from_ind ? op_mem : first_addr);

endmodule // nibble_addr_ctrl

// *** logic/nibble_alu.sv ***
// nibble alu datapath with operand latches, status word and apb status access
// assumes one operation at a time from the decoder and a data memory whose
// read data follows the sampled read address by one cycle
`timescale 1ns/1ps
module nibble_alu (
   // apb slave
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // instruction decoder
   input  wire logic                 op_valid,
   input  wire nibble_alu_pkg::op_t  op_code,
   input  wire logic [3:0]           op_reg,
   input  wire logic [7:0]           op_mem,
   input  wire logic [3:0]           op_imm,
   input  wire logic                 op_imm_sel,
   input  wire logic                 op_reg_dest,
   output logic                      op_ready,
   output logic                      op_done,
   output logic                      op_skip,
   // data memory
   output logic                      mem_rd_en,
   output logic      [7:0]           mem_rd_addr,
   input  wire logic [3:0]           mem_rd_data,
   output logic                      mem_wr_en,
   output logic      [7:0]           mem_wr_addr,
   output logic      [3:0]           mem_wr_data,
   // status word
   output logic                      decimal_mode,
   output logic                      compare_only_flag,
   output logic                      carry_flag,
   output logic                      zero_flag
);

   typedef enum logic [2:0] {
      S_IDLE, S_RD_A, S_GET_A, S_RD_B, S_GET_B, S_EXEC
   } state_t;

   state_t              state_q;
   nibble_alu_pkg::op_t op_q;
   logic [3:0]          reg_q;
   logic [7:0]          mem_q;
   logic                imm_q;
   logic                reg_dest_q;
   logic [3:0]          latch_a_q;
   logic [3:0]          latch_b_q;
   logic                rd_en_q;
   logic [7:0]          rd_addr_q;
   logic                wr_en_q;
   logic [7:0]          wr_addr_q;
   logic [3:0]          wr_data_q;
   logic                done_q;
   logic                skip_q;
   logic [3:0]          result_q;
   logic                bcd_q;
   logic                conly_q;
   logic                carry_q;
   logic                z_q;
   logic [31:0]         prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // operation class decode
   wire logic is_add    = (op_q == nibble_alu_pkg::OP_SUM) ||
                          (op_q == nibble_alu_pkg::OP_SUM_CARRY);
   wire logic is_sub    = (op_q == nibble_alu_pkg::OP_DIFF) ||
                          (op_q == nibble_alu_pkg::OP_DIFF_BORROW);
   wire logic use_cin   = (op_q == nibble_alu_pkg::OP_SUM_CARRY) ||
                          (op_q == nibble_alu_pkg::OP_DIFF_BORROW);
   wire logic is_arith  = is_add | is_sub;
   wire logic is_logic  = (op_q == nibble_alu_pkg::OP_AND) ||
                          (op_q == nibble_alu_pkg::OP_OR)  ||
                          (op_q == nibble_alu_pkg::OP_XOR);
   wire logic is_bits   = (op_q == nibble_alu_pkg::OP_BITS_TRUE) ||
                          (op_q == nibble_alu_pkg::OP_BITS_FALSE);
   wire logic is_rel_op = (op_q == nibble_alu_pkg::OP_EQUAL)   ||
                          (op_q == nibble_alu_pkg::OP_UNEQUAL) ||
                          (op_q == nibble_alu_pkg::OP_GREATER_EQUAL) ||
                          (op_q == nibble_alu_pkg::OP_LESS);
   wire logic is_rot    = (op_q == nibble_alu_pkg::OP_ROTATE);
   wire logic to_ind    = (op_q == nibble_alu_pkg::OP_MOVE_TO_IND);
   wire logic from_ind  = (op_q == nibble_alu_pkg::OP_MOVE_FROM_IND);
   wire logic is_move   = to_ind | from_ind |
                          (op_q == nibble_alu_pkg::OP_LOAD) ||
                          (op_q == nibble_alu_pkg::OP_STORE);

   ////////////////////////////////////////////////////////////////////////////
   // operand fetch: system nibbles come from the status flops, not memory
   wire logic [6:0] rd_sys  = rd_addr_q[6:0];
   wire logic [3:0] psw_nib = {conly_q, carry_q, z_q, 1'b0};
   wire logic [3:0] rd_val  = (rd_sys == nibble_alu_pkg::SYS_PSW_ADDR) ? psw_nib :
                              (rd_sys == nibble_alu_pkg::SYS_BCD_ADDR) ? {3'b000, bcd_q} :
                              mem_rd_data;

   // indirect column comes live from memory while the register nibble arrives
   wire logic [3:0] ind_col = (state_q == S_GET_A) ? rd_val : latch_a_q;
   wire logic [7:0] first_addr;
   wire logic [7:0] second_addr;
   wire logic [7:0] dest_addr;
   wire logic [7:0] new_first;

   nibble_addr_ctrl u_addr (
      .op_reg      (reg_q),
      .op_mem      (mem_q),
      .reg_dest    (reg_dest_q),
      .to_ind      (to_ind),
      .from_ind    (from_ind),
      .reg_only    (is_rot),
      .ind_col     (ind_col),
      .first_addr  (first_addr),
      .second_addr (second_addr),
      .dest_addr   (dest_addr)
   );

   // first address of an incoming operation, before its fields are latched
   nibble_addr_ctrl u_addr_new (
      .op_reg      (op_reg),
      .op_mem      (op_mem),
      .reg_dest    (op_reg_dest),
      .to_ind      (op_code == nibble_alu_pkg::OP_MOVE_TO_IND),
      .from_ind    (op_code == nibble_alu_pkg::OP_MOVE_FROM_IND),
      .reg_only    (op_code == nibble_alu_pkg::OP_ROTATE),
      .ind_col     (4'h0),
      .first_addr  (new_first),
      .second_addr (),
      .dest_addr   ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic core
   wire logic       cin     = use_cin & carry_q;
   wire logic [4:0] add_raw = {1'b0, latch_a_q} + {1'b0, latch_b_q} + {4'h0, cin};
   wire logic [4:0] sub_raw = {1'b0, latch_a_q} - {1'b0, latch_b_q} - {4'h0, cin};
   wire logic [4:0] raw     = is_sub ? sub_raw : add_raw;
   wire logic [3:0] adj_val;
   wire logic       adj_carry;

   decimal_adjuster u_adj (
      .raw       (raw),
      .is_sub    (is_sub),
      .adj       (adj_val),
      .adj_carry (adj_carry)
   );

   wire logic [3:0] arith_val = bcd_q ? adj_val : raw[3:0];
   wire logic       arith_carry = bcd_q ? adj_carry : raw[4];
   wire logic       arith_z   = (arith_val == 4'h0);

   wire logic [3:0] rot_val = {carry_q, latch_a_q[3:1]};

   wire logic [3:0] and_val = latch_a_q & latch_b_q;
   wire logic [3:0] logic_val =
      (op_q == nibble_alu_pkg::OP_AND) ? and_val :
      (op_q == nibble_alu_pkg::OP_OR)  ? (latch_a_q | latch_b_q) :
                                         (latch_a_q ^ latch_b_q);

   wire logic skip_cond =
      (op_q == nibble_alu_pkg::OP_BITS_TRUE)     ? (and_val == latch_b_q) :
      (op_q == nibble_alu_pkg::OP_BITS_FALSE)    ? (and_val == 4'h0) :
      (op_q == nibble_alu_pkg::OP_EQUAL)         ? (latch_a_q == latch_b_q) :
      (op_q == nibble_alu_pkg::OP_UNEQUAL)       ? (latch_a_q != latch_b_q) :
      (op_q == nibble_alu_pkg::OP_GREATER_EQUAL) ? (latch_a_q >= latch_b_q) :
      (op_q == nibble_alu_pkg::OP_LESS)          ? (latch_a_q <  latch_b_q) :
                                                   1'b0;

   wire logic [3:0] exec_val = is_arith ? arith_val :
                               is_logic ? logic_val :
                               is_rot   ? rot_val   :
                                          latch_b_q;

   ////////////////////////////////////////////////////////////////////////////
   // destination and status-word targeting
   wire logic exec     = (state_q == S_EXEC);
   wire logic dst_psw  = (dest_addr[6:0] == nibble_alu_pkg::SYS_PSW_ADDR);
   wire logic dst_bcd  = (dest_addr[6:0] == nibble_alu_pkg::SYS_BCD_ADDR);
   wire logic dst_sys  = dst_psw | dst_bcd;
   wire logic arith_st = is_arith & ~conly_q;
   wire logic want_wr  = arith_st | is_logic | is_rot | is_move;
   wire logic psw_ovr  = exec & arith_st & dst_psw;
   wire logic bcd_ovr  = exec & arith_st & dst_bcd;

   wire logic z_exec   = conly_q ? (z_q & arith_z) : arith_z;

   wire logic touch_carry = exec & (is_arith | is_rot);
   wire logic touch_z     = exec & is_arith;
   wire logic touch_conly = exec & is_bits;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire logic apb_setup = psel & ~penable;
   wire logic apb_acc   = psel & penable;
   wire logic hit_stat  = (paddr == nibble_alu_pkg::OFS_STATUS);
   wire logic hit_state = (paddr == nibble_alu_pkg::OFS_STATE);
   wire logic hit_res   = (paddr == nibble_alu_pkg::OFS_RESULT);
   wire logic hit_any   = hit_stat | hit_state | hit_res;
   wire logic st_wr     = apb_acc & pwrite & hit_stat;

   wire logic [31:0] rd_word =
      hit_stat  ? {28'h000_0000, bcd_q, conly_q, carry_q, z_q} :
      hit_state ? {30'h0000_0000, skip_q, (state_q != S_IDLE)} :
      hit_res   ? {28'h000_0000, result_q} :
                  32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // flag next values: an alu update in the same cycle wins over software
   wire logic carry_d = psw_ovr     ? exec_val[nibble_alu_pkg::PSW_CARRY_POS] :
                        touch_carry ? (is_rot ? latch_a_q[0] : arith_carry) :
                        st_wr       ? pwdata[nibble_alu_pkg::ST_CARRY_POS] : carry_q;
   wire logic z_d   = psw_ovr   ? exec_val[nibble_alu_pkg::PSW_Z_POS] :
                      touch_z   ? z_exec :
                      st_wr     ? pwdata[nibble_alu_pkg::ST_ZERO_POS] : z_q;
   wire logic conly_d = psw_ovr     ? exec_val[nibble_alu_pkg::PSW_CONLY_POS] :
                        touch_conly ? 1'b0 :
                        st_wr       ? pwdata[nibble_alu_pkg::ST_CONLY_POS] : conly_q;
   wire logic bcd_d = bcd_ovr   ? exec_val[0] :
                      st_wr     ? pwdata[nibble_alu_pkg::ST_BCD_POS] : bcd_q;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   wire logic     accept = (state_q == S_IDLE) & op_valid;
   wire logic     imm_ok = op_imm_sel & ~op_reg_dest;
   wire logic     need_b = ~imm_q & ~is_rot;
   state_t        state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE:  if (op_valid) begin
            state_d = S_RD_A;
         end
         S_RD_A:  state_d = S_GET_A;
         S_GET_A: state_d = need_b ? S_RD_B : S_EXEC;
         S_RD_B:  state_d = S_GET_B;
         S_GET_B: state_d = S_EXEC;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= S_IDLE;
         op_q       <= nibble_alu_pkg::OP_LOAD;
         reg_q      <= 4'h0;
         mem_q      <= 8'h00;
         imm_q      <= 1'b0;
         reg_dest_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (accept) begin
            op_q       <= op_code;
            reg_q      <= op_reg;
            mem_q      <= op_mem;
            imm_q      <= imm_ok;
            reg_dest_q <= op_reg_dest;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_a_q <= 4'h0;
         latch_b_q <= 4'h0;
      end else begin
         if (state_q == S_GET_A) begin
            latch_a_q <= rd_val;
         end
         if (accept) begin
            latch_b_q <= op_imm;
         end else if (state_q == S_GET_B) begin
            latch_b_q <= rd_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_en_q   <= 1'b0;
         rd_addr_q <= 8'h00;
         wr_en_q   <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 4'h0;
      end else begin
         rd_en_q <= accept | ((state_q == S_GET_A) & need_b);
         if (accept) begin
            rd_addr_q <= new_first;
         end else if (state_q == S_GET_A) begin
            rd_addr_q <= second_addr;
         end
         wr_en_q <= exec & want_wr & ~dst_sys;
         if (exec) begin
            wr_addr_q <= dest_addr;
            wr_data_q <= exec_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q   <= 1'b0;
         skip_q   <= 1'b0;
         result_q <= 4'h0;
      end else begin
         done_q <= exec;
         if (exec) begin
            skip_q   <= (is_bits | is_rel_op) & skip_cond;
            result_q <= exec_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         z_q   <= nibble_alu_pkg::STATUS_RST[nibble_alu_pkg::ST_ZERO_POS];
         carry_q <= nibble_alu_pkg::STATUS_RST[nibble_alu_pkg::ST_CARRY_POS];
         conly_q <= nibble_alu_pkg::STATUS_RST[nibble_alu_pkg::ST_CONLY_POS];
         bcd_q   <= nibble_alu_pkg::STATUS_RST[nibble_alu_pkg::ST_BCD_POS];
      end else begin
         z_q     <= z_d;
         carry_q <= carry_d;
         conly_q <= conly_d;
         bcd_q   <= bcd_d;
      end
   end

   // read data captured in setup so the zero-wait access phase sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_setup & ~pwrite) begin
         prdata_q <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata            = prdata_q;
   assign pready            = 1'b1;
   assign pslverr           = apb_acc & ~hit_any;
   assign op_ready          = (state_q == S_IDLE);
   assign op_done           = done_q;
   assign op_skip           = skip_q;
   assign mem_rd_en         = rd_en_q;
   assign mem_rd_addr       = rd_addr_q;
   assign mem_wr_en         = wr_en_q;
   assign mem_wr_addr       = wr_addr_q;
   assign mem_wr_data       = wr_data_q;
   assign decimal_mode      = bcd_q;
   assign compare_only_flag = conly_q;
   assign carry_flag        = carry_q;
   assign zero_flag         = z_q;

endmodule // nibble_alu

// *** verif/nibble_alu_monitor.sv ***
// port assertions for the nibble alu: apb answer, handshake, flag causes
// assumes no status write by apb while an operation is in flight
`timescale 1ns/1ps
module nibble_alu_monitor (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   // decoder, memory and flags
   input wire logic op_valid,
   input wire logic op_ready,
   input wire logic op_done,
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire logic compare_only_flag,
   input wire logic carry_flag,
   input wire logic zero_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire apb_wr = psel && penable && pwrite;
   a_pready_high: assert property (pready)
      else $error("pready low");
   a_take_busy: assert property (op_valid && op_ready |=> !op_ready)
      else $error("ready after take");
   a_done_latency: assert property (op_valid && op_ready |=> !op_done [*3] ##[1:3] op_done)
      else $error("done latency");
   a_done_single: assert property (op_done |=> !op_done)
      else $error("done too long");
   a_read_spaced: assert property (mem_rd_en |=> !mem_rd_en)
      else $error("read spacing");
   a_write_in_done: assert property (mem_wr_en |-> op_done)
      else $error("write outside done");
   a_carry_cause: assert property ($changed(carry_flag) |-> op_done || $past(apb_wr))
      else $error("carry changed alone");
   a_zero_cmp_hold: assert property ($rose(zero_flag) && $past(compare_only_flag)
      |-> $past(apb_wr))
      else $error("zero set in compare");
endmodule // nibble_alu_monitor

// *** verif/data_mem_model.sv ***
// data memory stand-in: 256 nibbles, read data one cycle after the request
// assumes the bench preloads cells by hierarchical write between edges
`timescale 1ns/1ps
module data_mem_model (
   // clock
   input  wire logic       pclk,
   // ports
   input  wire logic       mem_rd_en,
   input  wire logic [7:0] mem_rd_addr,
   output logic      [3:0] mem_rd_data,
   input  wire logic       mem_wr_en,
   input  wire logic [7:0] mem_wr_addr,
   input  wire logic [3:0] mem_wr_data
);
   logic [3:0] mem [256];
   // outside a read the bus toggles, so a stale nibble cannot pass
   always @(posedge pclk) begin
      if (mem_wr_en) mem[mem_wr_addr] <= mem_wr_data;
      mem_rd_data <= mem_rd_en ? mem[mem_rd_addr] : ~mem_rd_data;
   end
endmodule // data_mem_model

// *** verif/tb.sv ***
// random alu operations against a reference model, status read over apb
// assumes the memory model and the bound port monitor
`timescale 1ns/1ps
module tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0;
   logic [11:0] paddr = '0, wr;
   logic [31:0] pwdata = '0, prdata, rd, seed = 32'h5bfc_f0aa;
   logic [7:0]  op_mem = '0, mem_rd_addr, mem_wr_addr, m;
   logic [3:0]  op_reg = '0, op_imm = '0, mem_rd_data, mem_wr_data, a, n, f, er;
   logic        pready, pslverr, op_ready, op_done, op_skip, mem_rd_en, mem_wr_en;
   logic        decimal_mode, compare_only_flag, carry_flag, zero_flag;
   logic        err, ws, sk, ecy, ez, ecm, ewr, esk, bad;
   int          fail_count = 0, n_compared = 0, v;
   nibble_alu_pkg::op_t op_code = nibble_alu_pkg::OP_SUM, c;
   nibble_alu i_nibble_alu (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .op_reg, .op_mem,
      .op_imm, .op_imm_sel(1'b1), .op_reg_dest(1'b0), .op_ready, .op_done, .op_skip,
      .mem_rd_en, .mem_rd_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data,
      .decimal_mode, .compare_only_flag, .carry_flag, .zero_flag);
   data_mem_model i_data_mem_model (.pclk, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
      .mem_wr_en, .mem_wr_addr, .mem_wr_data);
   always #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic run_op();
      @(posedge pclk);
      {op_valid, op_code, op_reg, op_mem, op_imm} <= {1'b1, c, m[3:0], m, n};
      do @(posedge pclk); while (op_ready !== 1'b1);
      op_valid <= 0;
      do @(posedge pclk); while (op_done !== 1'b1);
      {ws, wr, sk} = {mem_wr_en, mem_wr_addr, mem_wr_data, op_skip};
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, nibble_alu_pkg::OFS_STATUS, 0);
      chk(rd, nibble_alu_pkg::STATUS_RST);
      apb(1, 12'h0fc, '1);
      chk(err, 1);
      apb(0, 12'h0fc, 0);
      chk({err, rd}, {1'b1, 32'h0});
      for (int i = 0; i < 140; i++) begin
         seed = lfsr(seed);
         c = (i % 14 == 13) ? nibble_alu_pkg::OP_ROTATE : nibble_alu_pkg::op_t'(i % 14);
         {m, n, f, a} = {seed[7], 1'b0, seed[5:0], seed[15:4]};
         if (c == nibble_alu_pkg::OP_ROTATE) m[7:4] = nibble_alu_pkg::GR_ROW_BANK;
         i_data_mem_model.mem[m] = a;
         apb(1, nibble_alu_pkg::OFS_STATUS, {28'h0, f});
         {ecm, ecy, ez, ewr, esk, bad, er} = {f[2:0], 3'b100, 4'h0};
         case (c)
            nibble_alu_pkg::OP_AND: er = a & n;
            nibble_alu_pkg::OP_OR: er = a | n;
            nibble_alu_pkg::OP_XOR: er = a ^ n;
            nibble_alu_pkg::OP_ROTATE: {er, ecy} = {f[1], a};
            nibble_alu_pkg::OP_BITS_TRUE: {ewr, ecm, esk} = {2'b00, (a & n) == n};
            nibble_alu_pkg::OP_BITS_FALSE: {ewr, ecm, esk} = {2'b00, (a & n) == 0};
            nibble_alu_pkg::OP_EQUAL: {ewr, esk} = {1'b0, a == n};
            nibble_alu_pkg::OP_UNEQUAL: {ewr, esk} = {1'b0, a != n};
            nibble_alu_pkg::OP_GREATER_EQUAL: {ewr, esk} = {1'b0, a >= n};
            nibble_alu_pkg::OP_LESS: {ewr, esk} = {1'b0, a < n};
            default: begin
               v = c[1] ? int'(a) - n - (c[0] & f[1]) : int'(a) + n + (c[0] & f[1]);
               ecy = v < 0 || v > (f[3] ? 9 : 15);
               er = (f[3] && v > 9) ? v - 10 : (f[3] && v < 0) ? v + 10 : v;
               bad = f[3] && (c[1] ? (v > 9 || v < -10) : v > 19);
               ez = er == 0 && !(f[2] && !f[0]);
               ewr = !f[2];
            end
         endcase
         run_op();
         chk(ws, ewr);
         if (ewr && !bad) chk(wr, {m, er});
         if (ewr && bad) chk(wr[3:0] > 9, 1);
         chk(sk, esk);
         apb(0, nibble_alu_pkg::OFS_STATUS, 0);
         chk(rd | bad, {28'h0, f[3], ecm, ecy, ez | bad});
         chk({decimal_mode, compare_only_flag, carry_flag, zero_flag | bad}, {f[3], ecm, ecy, ez | bad});
      end
      report_and_stop();
   end
endmodule // tb
bind nibble_alu nibble_alu_monitor i_nibble_alu_monitor (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .op_valid, .op_ready, .op_done, .mem_rd_en, .mem_wr_en,
   .compare_only_flag, .carry_flag, .zero_flag);
